// File: src/dpf_pkg.sv
// Notes on behaviour
// - flag collision when the clock falls while a repeated start is awaited.
// - a stop ends the transfer and returns the interface to idle.
// - the clock line is never driven; answers come without stretching.
// - malformed frames are dropped; start or stop mid-byte aborts it.
// - first byte after start is the address: 01011, two pin bits, r/w.
// - low address pin level is caught only on a power-on or brownout event.
// - byte 0000 1xxx after start is not acknowledged but enters fast mode.
// - fast mode survives repeated starts and ends at the next stop.
// - after broadcast address only own command codes are acknowledged.
// - only the first command per broadcast address; later bytes not acknowledged.
// - code 100000d writes next byte to wiper 0, d as ninth bit.
// - code 100100d writes next byte to wiper 1, d as ninth bit.
// - code 110000d writes next byte plus d to terminal control register.
// - codes 1000010 and 1000011 step wiper 0 up.
// - codes 1001010 and 1001011 step wiper 1 up.
// - codes 1000100 and 1000101 step wiper 0 down.
// - codes 1001100 and 1001101 step wiper 1 down.
// - command is seven bits in upper byte bits with a zero lsb.
// - start is data falling with clock high; it begins a transfer.
// - data is sampled on each clock rising edge while receiving.
// - matching address acknowledged, other addresses not acknowledged.
// - broadcast address acknowledged only while broadcast enable is set.
package dpf_pkg;
    localparam logic [4:0] FIXED_ADDR = 5'h0B;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [5:0] GC_WR_W0 = 6'h20;
    localparam logic [5:0] GC_WR_W1 = 6'h24;
    localparam logic [5:0] GC_WR_TERMINAL_CONTROL_REG = 6'h30;
    localparam logic [5:0] GC_INC_W0 = 6'h21;
    localparam logic [5:0] GC_INC_W1 = 6'h25;
    localparam logic [5:0] GC_DEC_W0 = 6'h22;
    localparam logic [5:0] GC_DEC_W1 = 6'h26;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] END_SLOT = 4'h9;
    localparam logic RST_HS = 1'b0;
    localparam logic RST_A0 = 1'b0;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        OP_WR_W0, OP_WR_W1, OP_WR_TERMINAL_CONTROL_REG, OP_INC_W0,
        OP_INC_W1, OP_DEC_W0, OP_DEC_W1, OP_DATA
    } dpf_op_e;

    typedef struct packed {
        dpf_op_e op;
        logic first;
        logic [8:0] value;
    } dpf_cmd_s;

    typedef struct packed {
        logic scl;
        logic sda;
    } dpf_bus_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_GCCMD, ST_GCDATA,
        ST_WRDATA, ST_RDDATA, ST_IGNORE, ST_SRWAIT
    } dpf_state_e;
endpackage : dpf_pkg

// File: src/dpf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dpf_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic full, empty;

    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = (wp_q == rp_q);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp_q[AW-1:0]];

    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        if (in_valid && !full) begin
            wp_d = wp_q + 1'b1;
        end
        if (out_ready && !empty) begin
            rp_d = rp_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // storage needs no reset; only pointers decide validity
    always_ff @(posedge sys_clk) begin
        if (in_valid && !full) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule : dpf_fifo
`default_nettype wire

// File: src/dpf_front.sv
`timescale 1ns/1ps
`default_nettype none
module dpf_front (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_low_pin,
    input wire logic addr_select_high_pin,
    input wire logic power_on_brownout_event,
    input wire logic broadcast_enable_bit,
    input wire logic [7:0] rd_data,
    output logic rd_taken,
    output logic hs_mode,
    output logic bus_collision,
    output logic frame_abort,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output dpf_pkg::dpf_cmd_s cmd_data
);
    dpf_pkg::dpf_bus_s pin_m, pin_q, pin_p;
    logic [3:0] cfg_m, cfg_q;
    logic a0_q, a0_d;
    dpf_pkg::dpf_state_e st_q, st_d;
    logic [3:0] bitn_q, bitn_d;
    logic [7:0] sh_q, sh_d, tx_q, tx_d;
    logic oe_q, oe_d, hs_q, hs_d, mack_q, mack_d;
    logic first_q, first_d, dbit_q, dbit_d;
    dpf_pkg::dpf_op_e op_q, op_d;
    logic coll_q, coll_d, abort_q, abort_d, rdt_q, rdt_d;
    logic rise, fall, start, stop, own_hit, gc_hit, hs_hit;
    logic push, push_rdy;
    dpf_pkg::dpf_cmd_s push_data;
    logic [4:0] gc;

    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_m <= '1;
            pin_q <= '1;
            pin_p <= '1;
            cfg_m <= '0;
            cfg_q <= '0;
        end else begin
            pin_m <= '{scl: scl_pin, sda: sda_pin};
            pin_q <= pin_m;
            pin_p <= pin_q;
            cfg_m <= {power_on_brownout_event, broadcast_enable_bit,
                      addr_select_high_pin, addr_select_low_pin};
            cfg_q <= cfg_m;
        end
    end

    assign rise = pin_q.scl && !pin_p.scl;
    assign fall = !pin_q.scl && pin_p.scl;
    assign start = pin_q.scl && pin_p.scl && pin_p.sda && !pin_q.sda;
    assign stop = pin_q.scl && pin_p.scl && !pin_p.sda && pin_q.sda;

    assign a0_d = cfg_q[3] ? cfg_q[0] : a0_q;

    assign own_hit = sh_q[7:1] == {dpf_pkg::FIXED_ADDR, cfg_q[1], a0_q};
    assign gc_hit = sh_q == dpf_pkg::GC_ADDR;
    assign hs_hit = sh_q[7:3] == dpf_pkg::HS_CODE_TOP;

    // returns {valid, is_write, op}
    function automatic logic [4:0] gc_decode(input logic [7:0] b);
        logic [4:0] r;
        r = '0;
        if (!b[0]) begin
            unique case (b[7:2])
                dpf_pkg::GC_WR_W0: r = {2'b11, dpf_pkg::OP_WR_W0};
                dpf_pkg::GC_WR_W1: r = {2'b11, dpf_pkg::OP_WR_W1};
                dpf_pkg::GC_WR_TERMINAL_CONTROL_REG: r = {2'b11, dpf_pkg::OP_WR_TERMINAL_CONTROL_REG};
                dpf_pkg::GC_INC_W0: r = {2'b10, dpf_pkg::OP_INC_W0};
                dpf_pkg::GC_INC_W1: r = {2'b10, dpf_pkg::OP_INC_W1};
                dpf_pkg::GC_DEC_W0: r = {2'b10, dpf_pkg::OP_DEC_W0};
                dpf_pkg::GC_DEC_W1: r = {2'b10, dpf_pkg::OP_DEC_W1};
                default: r = '0;
            endcase
        end
        return r;
    endfunction : gc_decode

    always_comb begin
        st_d = st_q;
        bitn_d = bitn_q;
        sh_d = sh_q;
        tx_d = tx_q;
        oe_d = oe_q;
        hs_d = hs_q;
        mack_d = mack_q;
        first_d = first_q;
        dbit_d = dbit_q;
        op_d = op_q;
        coll_d = 1'b0;
        abort_d = 1'b0;
        rdt_d = 1'b0;
        push = 1'b0;
        push_data = '{op: op_q, first: first_q, value: {dbit_q, sh_q}};
        gc = gc_decode(sh_q);
        if (stop) begin
            st_d = dpf_pkg::ST_IDLE;
            hs_d = 1'b0;
            oe_d = 1'b0;
            // stop mid-byte; its own clock rise already counts one bit
            abort_d = (st_q != dpf_pkg::ST_IDLE) && (bitn_q > 4'h1);
        end else if (start) begin
            st_d = dpf_pkg::ST_ADDR;
            bitn_d = 4'h0;
            oe_d = 1'b0;
            abort_d = (st_q != dpf_pkg::ST_IDLE) && (bitn_q > 4'h1);
        end else if (st_q == dpf_pkg::ST_SRWAIT) begin
            // clock fell with no repeated start seen
            if (fall) begin
                coll_d = 1'b1;
                st_d = dpf_pkg::ST_IDLE;
            end
        end else if (st_q != dpf_pkg::ST_IDLE) begin
            if (rise) begin
                if (bitn_q < dpf_pkg::ACK_SLOT) begin
                    sh_d = {sh_q[6:0], pin_q.sda};
                end else if (bitn_q == dpf_pkg::ACK_SLOT) begin
                    mack_d = !pin_q.sda;
                end
                if (bitn_q < dpf_pkg::END_SLOT) begin
                    bitn_d = bitn_q + 4'h1;
                end
            end
            if (fall) begin
                if (bitn_q == dpf_pkg::ACK_SLOT) begin
                    oe_d = 1'b0;
                    unique case (st_q)
                        dpf_pkg::ST_ADDR: begin
                            if (hs_hit) begin
                                hs_d = 1'b1;
                            end else begin
                                oe_d = own_hit || (gc_hit && cfg_q[2]);
                            end
                        end
                        dpf_pkg::ST_GCCMD: oe_d = gc[4] && push_rdy;
                        dpf_pkg::ST_GCDATA: oe_d = push_rdy;
                        dpf_pkg::ST_WRDATA: oe_d = push_rdy;
                        default: oe_d = 1'b0;
                    endcase
                end else if (bitn_q == dpf_pkg::END_SLOT) begin
                    oe_d = 1'b0;
                    bitn_d = 4'h0;
                    st_d = dpf_pkg::ST_IGNORE;
                    unique case (st_q)
                        dpf_pkg::ST_ADDR: begin
                            if (oe_q && gc_hit) begin
                                st_d = dpf_pkg::ST_GCCMD;
                            end else if (oe_q && sh_q[0]) begin
                                // read byte ready at once: no stretching
                                st_d = dpf_pkg::ST_RDDATA;
                                tx_d = rd_data;
                                rdt_d = 1'b1;
                                oe_d = !rd_data[7];
                            end else if (oe_q) begin
                                st_d = dpf_pkg::ST_WRDATA;
                                first_d = 1'b1;
                            end
                        end
                        dpf_pkg::ST_GCCMD: begin
                            op_d = dpf_dec_op(gc);
                            dbit_d = sh_q[1];
                            if (oe_q && gc[3]) begin
                                st_d = dpf_pkg::ST_GCDATA;
                            end else if (oe_q) begin
                                push = 1'b1;
                                push_data.op = dpf_dec_op(gc);
                                push_data.first = 1'b1;
                            end
                        end
                        dpf_pkg::ST_GCDATA: begin
                            push = oe_q;
                            push_data.first = 1'b1;
                        end
                        dpf_pkg::ST_WRDATA: begin
                            if (oe_q) begin
                                push = 1'b1;
                                push_data = '{op: dpf_pkg::OP_DATA, first: first_q,
                                              value: {1'b0, sh_q}};
                                first_d = 1'b0;
                                st_d = dpf_pkg::ST_WRDATA;
                            end
                        end
                        dpf_pkg::ST_RDDATA: begin
                            if (mack_q) begin
                                st_d = dpf_pkg::ST_RDDATA;
                                tx_d = rd_data;
                                rdt_d = 1'b1;
                                oe_d = !rd_data[7];
                            end else begin
                                // master must now restart or stop
                                st_d = dpf_pkg::ST_SRWAIT;
                            end
                        end
                        default: st_d = dpf_pkg::ST_IGNORE;
                    endcase
                end else if (st_q == dpf_pkg::ST_RDDATA && bitn_q != 4'h0) begin
                    oe_d = !tx_q[3'h7 - bitn_q[2:0]];
                end
            end
        end
    end

    function automatic dpf_pkg::dpf_op_e dpf_dec_op(input logic [4:0] g);
        return dpf_pkg::dpf_op_e'(g[2:0]);
    endfunction : dpf_dec_op

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= dpf_pkg::ST_IDLE;
            bitn_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            hs_q <= dpf_pkg::RST_HS;
            mack_q <= 1'b0;
            first_q <= 1'b0;
            dbit_q <= 1'b0;
            op_q <= dpf_pkg::OP_DATA;
            coll_q <= 1'b0;
            abort_q <= 1'b0;
            rdt_q <= 1'b0;
            a0_q <= dpf_pkg::RST_A0;
        end else begin
            st_q <= st_d;
            bitn_q <= bitn_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            oe_q <= oe_d;
            hs_q <= hs_d;
            mack_q <= mack_d;
            first_q <= first_d;
            dbit_q <= dbit_d;
            op_q <= op_d;
            coll_q <= coll_d;
            abort_q <= abort_d;
            rdt_q <= rdt_d;
            a0_q <= a0_d;
        end
    end

    dpf_fifo #(
        .WIDTH($bits(dpf_pkg::dpf_cmd_s)),
        .DEPTH(dpf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(push),
        .in_ready(push_rdy),
        .in_data(push_data),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(cmd_data)
    );

    // only data line pulled low, clock never driven
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign hs_mode = hs_q;
    assign bus_collision = coll_q;
    assign frame_abort = abort_q;
    assign rd_taken = rdt_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_stop_idle;
        stop |=> st_q == dpf_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop left busy");

    property p_stop_hs;
        stop |=> !hs_mode;
    endproperty
    a_stop_hs: assert property (p_stop_hs) else $error("fast mode kept after stop");

    property p_start_addr;
        start |=> st_q == dpf_pkg::ST_ADDR && bitn_q == 4'h0 && $stable(hs_mode);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not handled");

    property p_hs_code;
        fall && bitn_q == 4'h8 && st_q == dpf_pkg::ST_ADDR && hs_hit && !stop && !start
            |=> hs_mode && !sda_oe;
    endproperty
    a_hs_code: assert property (p_hs_code) else $error("master code misread");

    property p_addr_ack;
        fall && bitn_q == 4'h8 && st_q == dpf_pkg::ST_ADDR && own_hit && !start && !stop
            |=> sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

    property p_gc_off;
        fall && bitn_q == 4'h8 && st_q == dpf_pkg::ST_ADDR && gc_hit && !cfg_q[2]
            |=> !sda_oe;
    endproperty
    a_gc_off: assert property (p_gc_off) else $error("broadcast acked while off");

    property p_ignore_nack;
        st_q == dpf_pkg::ST_IGNORE |-> !sda_oe;
    endproperty
    a_ignore_nack: assert property (p_ignore_nack) else $error("ignored byte acked");

    property p_push_late;
        push |-> fall && bitn_q == 4'h9 && oe_q;
    endproperty
    a_push_late: assert property (p_push_late) else $error("push before ack done");

    property p_coll;
        st_q == dpf_pkg::ST_SRWAIT && fall && !start && !stop
            |=> bus_collision && st_q == dpf_pkg::ST_IDLE ##1 !bus_collision;
    endproperty
    a_coll: assert property (p_coll) else $error("collision missed");

    property p_abort;
        (start || stop) && st_q != dpf_pkg::ST_IDLE && bitn_q > 4'h1 |=> frame_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not flagged");

    c_hs: cover property (hs_mode ##[1:1000] stop);
    c_gc_write: cover property (push && st_q == dpf_pkg::ST_GCDATA);
    c_coll: cover property (bus_collision);
    c_read: cover property (rd_taken ##[1:1000] rd_taken);
endmodule : dpf_front
`default_nettype wire

// File: sim/dpf_master.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural bus master; a released line reads high through the pull-up
module dpf_master (
    input wire logic sys_clk,
    input wire logic sda_oe,
    input wire logic sda_out,
    output logic scl,
    output logic sda
);
    logic sda_drv = 1'b1;

    initial begin
        scl = 1'b1;
    end

    // open drain: whichever party pulls low wins
    assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);

    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt

    // data settles while low, sampled late in high phase
    task automatic clk_bit(input logic b, output logic s);
        wt(2);
        sda_drv = b;
        wt(5);
        scl = 1'b1;
        wt(6);
        s = sda;
        scl = 1'b0;
    endtask : clk_bit

    task automatic start();
        wt(2);
        sda_drv = 1'b1;
        wt(5);
        scl = 1'b1;
        wt(6);
        sda_drv = 1'b0;
        wt(6);
        scl = 1'b0;
    endtask : start

    // stop, called only with the clock low
    task automatic stop();
        wt(2);
        sda_drv = 1'b0;
        wt(5);
        scl = 1'b1;
        wt(6);
        sda_drv = 1'b1;
        wt(8);
    endtask : stop

    // msb first; a short count leaves the byte unfinished
    task automatic wbyte(input logic [7:0] b, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            clk_bit(b[i], s);
        end
        if (n == 8) begin
            clk_bit(1'b1, s);
            ack = ~s;
        end
    endtask : wbyte

    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        // acknowledge slot: low asks for more, high ends the read
        clk_bit(nack, s);
    endtask : rbyte

    // repeated start whose clock falls before data is pulled low
    task automatic drop_clk();
        wt(2);
        sda_drv = 1'b1;
        wt(5);
        scl = 1'b1;
        wt(6);
        scl = 1'b0;
    endtask : drop_clk
endmodule : dpf_master
`default_nettype wire

// File: sim/tb_dpf_front.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_dpf_front;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl, sda, sda_out, sda_oe, ak;
    logic a_lo = 1'b1, a_hi = 1'b0, pwr_ev = 1'b1, gc_en = 1'b1, cmd_ready = 1'b0;
    logic [7:0] rd_data = 8'hC3;
    logic [7:0] rb;
    logic rd_taken, hs_mode, bus_collision, frame_abort, cmd_valid;
    logic coll_seen = 1'b0;
    int n_abort = 0;
    dpf_pkg::dpf_cmd_s cmd_data;
    int err_total = 0, n_checks = 0;
    logic [7:0] gc_cb [11] = '{8'h82, 8'h90, 8'hC2, 8'h84, 8'h86, 8'h94, 8'h96, 8'h88, 8'h8A,
        8'h98, 8'h9A};
    logic [7:0] gc_db [11] = '{0: 8'hA5, 1: 8'h3C, 2: 8'hFF, default: 8'h00};
    dpf_pkg::dpf_op_e gc_op [11] = '{dpf_pkg::OP_WR_W0, dpf_pkg::OP_WR_W1, dpf_pkg::OP_WR_TERMINAL_CONTROL_REG,
        dpf_pkg::OP_INC_W0, dpf_pkg::OP_INC_W0, dpf_pkg::OP_INC_W1, dpf_pkg::OP_INC_W1,
        dpf_pkg::OP_DEC_W0, dpf_pkg::OP_DEC_W0, dpf_pkg::OP_DEC_W1, dpf_pkg::OP_DEC_W1};
    logic [7:0] bad_cb [4] = '{8'h06, 8'h04, 8'h85, 8'hF0};

    dpf_front uut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .scl_pin(scl),
        .sda_pin(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_select_low_pin(a_lo),
        .addr_select_high_pin(a_hi),
        .power_on_brownout_event(pwr_ev),
        .broadcast_enable_bit(gc_en),
        .rd_data(rd_data),
        .rd_taken(rd_taken),
        .hs_mode(hs_mode),
        .bus_collision(bus_collision),
        .frame_abort(frame_abort),
        .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready),
        .cmd_data(cmd_data)
    );

    dpf_master mst (
        .sys_clk(sys_clk),
        .sda_oe(sda_oe),
        .sda_out(sda_out),
        .scl(scl),
        .sda(sda)
    );

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // pulses are one cycle wide, so keep a sticky copy
    always @(posedge sys_clk) begin
        if (frame_abort === 1'b1) n_abort <= n_abort + 1;
        if (bus_collision === 1'b1) coll_seen <= 1'b1;
    end

    always @(negedge sys_clk) begin
        if (rd_taken === 1'b1) rd_data <= rd_data + 8'h11;
    end

    task automatic complete_run();
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic wb(input logic [7:0] b, input logic exp_ak, input string nm);
        mst.wbyte(b, 8, ak);
        `CHK(nm, exp_ak, ak)
    endtask : wb

    task automatic pop(input dpf_pkg::dpf_op_e op, input logic fst, input logic [8:0] v,
        input logic cv);
        int k = 0;
        while (cmd_valid !== 1'b1 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 40) begin
            err_total++;
            $display("unexpected cmd_valid expected 1 seen 0");
            complete_run();
        end
        `CHK("cmd op", op, cmd_data.op)
        `CHK("cmd first", fst, cmd_data.first)
        if (cv) `CHK("cmd value", v, cmd_data.value)
        cmd_ready = 1'b1;
        @(negedge sys_clk);
        cmd_ready = 1'b0;
        @(negedge sys_clk);
    endtask : pop

    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge sys_clk);
        pwr_ev = 1'b0;
        repeat (4) @(negedge sys_clk);
        // low pin moves after the event; address must not follow it
        a_lo = 1'b0;
        mst.start();
        wb(8'h5A, 1'b1, "own addr ack");
        wb(8'h37, 1'b1, "data ack");
        wb(8'h11, 1'b1, "data ack");
        mst.stop();
        pop(dpf_pkg::OP_DATA, 1'b1, 9'h037, 1'b1);
        pop(dpf_pkg::OP_DATA, 1'b0, 9'h011, 1'b1);
        mst.start();
        wb(8'h58, 1'b0, "foreign addr nack");
        mst.stop();
        a_hi = 1'b1;
        mst.start();
        wb(8'h5E, 1'b1, "high pin addr ack");
        mst.stop();
        a_hi = 1'b0;
        for (int i = 0; i < 11; i++) begin
            mst.start();
            wb(8'h00, 1'b1, "gc addr ack");
            wb(gc_cb[i], 1'b1, "gc cmd ack");
            if (i < 3) begin
                wb(gc_db[i], 1'b1, "gc data ack");
            end
            wb(8'h84, 1'b0, "second cmd nack");
            mst.stop();
            pop(gc_op[i], 1'b1, {gc_cb[i][1], gc_db[i]}, i < 3);
        end
        foreach (bad_cb[i]) begin
            mst.start();
            wb(8'h00, 1'b1, "gc addr ack");
            wb(bad_cb[i], 1'b0, "foreign code nack");
            mst.stop();
        end
        `CHK("no push", 1'b0, cmd_valid)
        gc_en = 1'b0;
        mst.start();
        wb(8'h00, 1'b0, "gc disabled nack");
        mst.stop();
        gc_en = 1'b1;
        mst.start();
        wb(8'h00, 1'b1, "gc addr ack");
        wb(8'h82, 1'b1, "gc cmd ack");
        `CHK("no clean frame abort", 0, n_abort)
        mst.wbyte(8'hA5, 4, ak);
        mst.stop();
        `CHK("abort count", 1, n_abort)
        `CHK("no partial push", 1'b0, cmd_valid)
        mst.start();
        wb(8'h09, 1'b0, "master code nack");
        `CHK("hs entry", 1'b1, hs_mode)
        mst.start();
        wb(8'h5A, 1'b1, "hs addr ack");
        wb(8'h44, 1'b1, "hs data ack");
        `CHK("hs kept", 1'b1, hs_mode)
        mst.stop();
        `CHK("hs exit", 1'b0, hs_mode)
        pop(dpf_pkg::OP_DATA, 1'b1, 9'h044, 1'b1);
        mst.start();
        wb(8'h5B, 1'b1, "read addr ack");
        mst.rbyte(1'b0, rb);
        `CHK("read byte 0", 8'hC3, rb)
        mst.rbyte(1'b1, rb);
        `CHK("read byte 1", 8'hD4, rb)
        `CHK("no early collision", 1'b0, coll_seen)
        mst.drop_clk();
        repeat (8) @(negedge sys_clk);
        `CHK("collision", 1'b1, coll_seen)
        mst.stop();
        for (int i = 0; i < 9; i++) begin
            mst.start();
            wb(8'h00, 1'b1, "gc addr ack");
            wb(8'h84, i < 8, "fifo fill ack");
            mst.stop();
        end
        for (int i = 0; i < 8; i++) begin
            pop(dpf_pkg::OP_INC_W0, 1'b1, 9'h000, 1'b0);
        end
        `CHK("fifo empty", 1'b0, cmd_valid)
        `CHK("no late abort", 1, n_abort)
        complete_run();
    end
endmodule : tb_dpf_front
`default_nettype wire
